// *** include/cogt_pkg.sv ***
// package: register map, field layout and types of the core trim bank
package cogt_pkg;

  localparam int unsigned ADDR_W     = 12;
  localparam int unsigned DATA_W     = 16;
  localparam int unsigned OFS_W      = 12;
  localparam int unsigned GAIN_W     = 5;
  localparam int unsigned N_OFS      = 6;
  localparam int unsigned N_GAIN     = 3;
  localparam int unsigned FUSE_CYCLES = 2;

  // byte addresses; gain registers are byte wide on odd and even addresses
  localparam logic [ADDR_W-1:0] TRIM_C2A_ADDR = 12'h334;
  localparam logic [ADDR_W-1:0] TRIM_C2B_ADDR = 12'h336;
  localparam logic [ADDR_W-1:0] TRIM_C3C_ADDR = 12'h338;
  localparam logic [ADDR_W-1:0] TRIM_C3D_ADDR = 12'h33a;
  localparam logic [ADDR_W-1:0] TRIM_C4_ADDR  = 12'h33c;
  localparam logic [ADDR_W-1:0] TRIM_C5_ADDR  = 12'h33e;
  localparam logic [ADDR_W-1:0] GAIN_C0_ADDR  = 12'h360;
  localparam logic [ADDR_W-1:0] GAIN_C1_ADDR  = 12'h361;
  localparam logic [ADDR_W-1:0] GAIN_C2A_ADDR = 12'h362;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 12'h370;

  localparam logic [OFS_W-1:0]  OFS_RESET  = 12'h000;
  localparam logic [GAIN_W-1:0] GAIN_RESET = 5'h00;

  typedef enum logic [2:0] {
    COGT_C2A, COGT_C2B, COGT_C3C, COGT_C3D, COGT_C4, COGT_C5
  } cogt_ofs_e;

  // factory trim image delivered by fuse storage
  typedef struct packed {
    logic [N_OFS-1:0][OFS_W-1:0]   ofs;
    logic [N_GAIN-1:0][GAIN_W-1:0] gain;
  } cogt_fuse_s;

  // trims presented to the sample datapath
  typedef struct packed {
    logic [OFS_W-1:0]  core2_ofs;
    logic [GAIN_W-1:0] core2_gain;
    logic [OFS_W-1:0]  core3_ofs;
    logic [OFS_W-1:0]  core4_ofs;
    logic [OFS_W-1:0]  core5_ofs;
    logic [GAIN_W-1:0] core0_gain;
    logic [GAIN_W-1:0] core1_gain;
  } cogt_trim_s;

endpackage : cogt_pkg

// *** logic/cogt_trim_cell.sv ***
// one trim register with fuse preload and software write
`timescale 1ns/1ps
`default_nettype none
module cogt_trim_cell #(
  parameter int unsigned W = 12
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  input  wire logic         wr,
  input  wire logic [W-1:0] wr_val,
  output logic      [W-1:0] q
);
  // fuse load takes priority, then software write
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else if (load) begin
      q <= load_val;
    end else if (wr) begin
      q <= wr_val;
    end
  end
endmodule : cogt_trim_cell
`default_nettype wire

// *** logic/cogt_trim_regs.sv ***
// core offset and fine gain trim register bank
// Function
// - 12-bit core2 offset trim, used only while core2 samples input A
// - separate core2 offset trim used only while core2 samples input B
// - core3 offset trim used only while core3 samples input C
// - second core3 offset trim used only while core3 samples input D
// - core4 offset trim applied to every core4 sample
// - core5 offset trim applied to every core5 sample
// - after reset every trim register is preloaded from fuse storage
// - 5-bit fine gain trim for core0 in low bits of byte register
// - 5-bit fine gain trim applied to core1 samples
// - core2 fine gain trim used only while core2 samples input A
// - offset trim values are unsigned
`timescale 1ns/1ps
`default_nettype none
module cogt_trim_regs
  import cogt_pkg::*;
#(
  parameter int unsigned FUSE_WAIT = FUSE_CYCLES
) (
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  output logic      [DATA_W-1:0] rdata,
  input  wire cogt_fuse_s        fuse_data,
  input  wire logic              core2_sel_b,
  input  wire logic              core3_sel_d,
  output cogt_trim_s             trim,
  output logic                   fuse_done
);

  // ---------------------------------------------------------------
  // fuse preload sequencer
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {FS_WAIT, FS_LOAD, FS_DONE} cogt_fuse_e;

  cogt_fuse_e     fs_reg;
  cogt_fuse_e     fs_next;
  logic [7:0]     wait_reg;
  logic [7:0]     wait_next;
  logic           load;

  always_comb begin
    fs_next = fs_reg;
    case (fs_reg)
      FS_WAIT: begin
        if (wait_reg == 8'(FUSE_WAIT)) begin
          fs_next = FS_LOAD;
        end
      end
      FS_LOAD: begin
        fs_next = FS_DONE;
      end
      FS_DONE: begin
        fs_next = FS_DONE;
      end
      default: begin
        fs_next = FS_DONE;
      end
    endcase
  end

  assign load = (fs_reg == FS_LOAD);

  // count only while waiting, so the counter freezes once the image is taken
  assign wait_next = (fs_reg == FS_WAIT) ? wait_reg + 8'h01 : wait_reg;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fs_reg <= FS_WAIT;
    end else begin
      fs_reg <= fs_next;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wait_reg <= 8'h00;
    end else begin
      wait_reg <= wait_next;
    end
  end

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  // one-hot select of the offset trims, indexed by cogt_ofs_e
  function automatic logic [N_OFS-1:0] ofs_hit(input logic [ADDR_W-1:0] a);
    logic [N_OFS-1:0] h;
    h = '0;
    if (a == TRIM_C2A_ADDR) begin
      h[COGT_C2A] = 1'b1;
    end else if (a == TRIM_C2B_ADDR) begin
      h[COGT_C2B] = 1'b1;
    end else if (a == TRIM_C3C_ADDR) begin
      h[COGT_C3C] = 1'b1;
    end else if (a == TRIM_C3D_ADDR) begin
      h[COGT_C3D] = 1'b1;
    end else if (a == TRIM_C4_ADDR) begin
      h[COGT_C4] = 1'b1;
    end else if (a == TRIM_C5_ADDR) begin
      h[COGT_C5] = 1'b1;
    end
    return h;
  endfunction : ofs_hit

  // one-hot select of the gain trims: core0, core1, core2 on input a
  function automatic logic [N_GAIN-1:0] gain_hit(input logic [ADDR_W-1:0] a);
    logic [N_GAIN-1:0] h;
    h = '0;
    if (a == GAIN_C0_ADDR) begin
      h[0] = 1'b1;
    end else if (a == GAIN_C1_ADDR) begin
      h[1] = 1'b1;
    end else if (a == GAIN_C2A_ADDR) begin
      h[2] = 1'b1;
    end
    return h;
  endfunction : gain_hit

  // the status word holds the preload-done flag
  function automatic logic status_hit(input logic [ADDR_W-1:0] a);
    return (a == STATUS_ADDR);
  endfunction : status_hit

  // read words: the trim field sits in the low bits, reserved bits read zero
  function automatic logic [DATA_W-1:0] ofs_word_of(input logic [OFS_W-1:0] v);
    return {4'h0, v};
  endfunction : ofs_word_of

  function automatic logic [DATA_W-1:0] gain_word_of(input logic [GAIN_W-1:0] v);
    return {11'h000, v};
  endfunction : gain_word_of

  wire logic [N_OFS-1:0]  sel_ofs  = ofs_hit(addr);
  wire logic [N_GAIN-1:0] sel_gain = gain_hit(addr);
  wire logic              sel_stat = status_hit(addr);

  // write strobes per register; an unmapped address strobes nothing
  wire logic [N_OFS-1:0]  wr_ofs  = sel_ofs & {N_OFS{wr_en}};
  wire logic [N_GAIN-1:0] wr_gain = sel_gain & {N_GAIN{wr_en}};

  // only the trim field of the write word is kept
  wire logic [OFS_W-1:0]  wr_ofs_val  = wdata[OFS_W-1:0];
  wire logic [GAIN_W-1:0] wr_gain_val = wdata[GAIN_W-1:0];

  // ---------------------------------------------------------------
  // trim storage
  // ---------------------------------------------------------------
  logic [N_OFS-1:0][OFS_W-1:0]   ofs_q;
  logic [N_GAIN-1:0][GAIN_W-1:0] gain_q;

  genvar gi;
  generate
    for (gi = 0; gi < N_OFS; gi++) begin : g_ofs
      // reserved bits 15:12 are not stored
      cogt_trim_cell #(
        .W (OFS_W)
      ) u_cell (
        .clk      (clk),
        .resetn   (resetn),
        .load     (load),
        .load_val (fuse_data.ofs[gi]),
        .wr       (wr_ofs[gi]),
        .wr_val   (wr_ofs_val),
        .q        (ofs_q[gi])
      );
    end

    for (gi = 0; gi < N_GAIN; gi++) begin : g_gain
      // reserved bits 7:5 are not stored
      cogt_trim_cell #(
        .W (GAIN_W)
      ) u_cell (
        .clk      (clk),
        .resetn   (resetn),
        .load     (load),
        .load_val (fuse_data.gain[gi]),
        .wr       (wr_gain[gi]),
        .wr_val   (wr_gain_val),
        .q        (gain_q[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  wire logic [N_OFS-1:0][DATA_W-1:0]  ofs_word;
  wire logic [N_GAIN-1:0][DATA_W-1:0] gain_word;
  wire logic                          fuse_ok   = (fs_reg == FS_DONE);
  wire logic [DATA_W-1:0]             stat_word = sel_stat ? {15'h0000, fuse_ok} : '0;
  logic [DATA_W-1:0]                  rd_mux;

  genvar gj;
  generate
    for (gj = 0; gj < N_OFS; gj++) begin : g_ofs_rd
      assign ofs_word[gj] = sel_ofs[gj] ? ofs_word_of(ofs_q[gj]) : '0;
    end

    for (gj = 0; gj < N_GAIN; gj++) begin : g_gain_rd
      assign gain_word[gj] = sel_gain[gj] ? gain_word_of(gain_q[gj]) : '0;
    end
  endgenerate

  // the selects are one-hot, so at most one word is non-zero
  always_comb begin
    rd_mux = stat_word;
    for (int i = 0; i < N_OFS; i++) begin
      rd_mux = rd_mux | ofs_word[i];
    end
    for (int i = 0; i < N_GAIN; i++) begin
      rd_mux = rd_mux | gain_word[i];
    end
  end

  // read data stand for the one cycle after the strobe, zero otherwise
  wire logic [DATA_W-1:0] rdata_next = rd_en ? rd_mux : '0;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= '0;
    end else begin
      rdata <= rdata_next;
    end
  end

  // ---------------------------------------------------------------
  // trims to the sample datapath, chosen by the sampled input
  // ---------------------------------------------------------------
  // core2 on input b gets the constant GAIN_RESET as its gain trim, not a stored value
  wire logic [OFS_W-1:0]  c2_ofs  = core2_sel_b ? ofs_q[COGT_C2B] : ofs_q[COGT_C2A];
  wire logic [GAIN_W-1:0] c2_gain = core2_sel_b ? GAIN_RESET : gain_q[2];

  wire logic [OFS_W-1:0]  c3_ofs  = core3_sel_d ? ofs_q[COGT_C3D] : ofs_q[COGT_C3C];

  wire logic [OFS_W-1:0]  c4_ofs  = ofs_q[COGT_C4];
  wire logic [OFS_W-1:0]  c5_ofs  = ofs_q[COGT_C5];

  wire logic [GAIN_W-1:0] c0_gain = gain_q[0];
  wire logic [GAIN_W-1:0] c1_gain = gain_q[1];

  cogt_trim_s trim_next;
  wire logic  fuse_done_next = (fs_next == FS_DONE);

  always_comb begin
    trim_next            = '0;
    trim_next.core2_ofs  = c2_ofs;
    trim_next.core2_gain = c2_gain;
    trim_next.core3_ofs  = c3_ofs;
    trim_next.core4_ofs  = c4_ofs;
    trim_next.core5_ofs  = c5_ofs;
    trim_next.core0_gain = c0_gain;
    trim_next.core1_gain = c1_gain;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      trim <= '0;
    end else begin
      trim <= trim_next;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fuse_done <= 1'b0;
    end else begin
      fuse_done <= fuse_done_next;
    end
  end

endmodule : cogt_trim_regs
`default_nettype wire

// *** verification/cogt_trim_regs_sva.sv ***
// checker: port-level assertions of the core trim bank
`timescale 1ns/1ps
`default_nettype none
module cogt_trim_regs_sva
  import cogt_pkg::*;
(
  input wire logic              clk,
  input wire logic              resetn,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic              wr_en,
  input wire logic              rd_en,
  input wire logic [DATA_W-1:0] rdata,
  input wire cogt_fuse_s        fuse_data,
  input wire logic              core2_sel_b,
  input wire logic              core3_sel_d,
  input wire cogt_trim_s        trim,
  input wire logic              fuse_done
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // the trim seen by the datapath equals what software reads back, except the core2 gain while core2 samples input b
  property p_m(bit h, logic [11:0] t);
    rd_en && h |=> t == rdata[11:0];
  endproperty
  rd_idle_zero_a: assert property (!rd_en |=> rdata == 16'h0000)
    else $error("read data outside read slot");
  rsv_zero_a: assert property (rdata[15:12] == 4'h0)
    else $error("reserved bits not zero");
  c2a_ofs_a: assert property (p_m(addr == TRIM_C2A_ADDR && !core2_sel_b, trim.core2_ofs))
    else $error("core2 input a offset");
  c2b_ofs_a: assert property (p_m(addr == TRIM_C2B_ADDR && core2_sel_b, trim.core2_ofs))
    else $error("core2 input b offset");
  c3c_ofs_a: assert property (p_m(addr == TRIM_C3C_ADDR && !core3_sel_d, trim.core3_ofs))
    else $error("core3 input c offset");
  c3d_ofs_a: assert property (p_m(addr == TRIM_C3D_ADDR && core3_sel_d, trim.core3_ofs))
    else $error("core3 input d offset");
  c4_ofs_a: assert property (p_m(addr == TRIM_C4_ADDR, trim.core4_ofs))
    else $error("core4 offset");
  c5_ofs_a: assert property (p_m(addr == TRIM_C5_ADDR, trim.core5_ofs))
    else $error("core5 offset");
  c0_gain_a: assert property (p_m(addr == GAIN_C0_ADDR, {7'h00, trim.core0_gain}))
    else $error("core0 gain");
  c1_gain_a: assert property (p_m(addr == GAIN_C1_ADDR, {7'h00, trim.core1_gain}))
    else $error("core1 gain");
  c2_gain_a: assert property (p_m(addr == GAIN_C2A_ADDR && !core2_sel_b,
                                  {7'h00, trim.core2_gain}))
    else $error("core2 gain");
  c2b_gain_off_a: assert property (core2_sel_b |=> trim.core2_gain == 5'h00)
    else $error("core2 gain on input b");
  done_sticky_a: assert property (fuse_done |=> fuse_done)
    else $error("preload flag dropped");
  cover property (rd_en && addr == TRIM_C2B_ADDR && core2_sel_b);
  cover property (wr_en && addr == GAIN_C2A_ADDR);
  cover property ($rose(fuse_done));
endmodule : cogt_trim_regs_sva
bind cogt_trim_regs cogt_trim_regs_sva chk (.clk, .resetn, .addr, .wdata, .wr_en, .rd_en,
  .rdata, .fuse_data, .core2_sel_b, .core3_sel_d, .trim, .fuse_done);
`default_nettype wire

// *** verification/cogt_trim_regs_tb.sv ***
// testbench: register access and trim routing of the core trim bank
`timescale 1ns/1ps
`default_nettype none
module cogt_trim_regs_tb
  import cogt_pkg::*;
;
  logic clk, resetn, wr_en, rd_en, core2_sel_b, core3_sel_d, fuse_done;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata;
  cogt_fuse_s        fuse_data;
  cogt_trim_s        trim;
  int                n_fail, compares;
  logic [11:0]       ev [9];
  logic [ADDR_W-1:0] at [9] = '{TRIM_C2A_ADDR, TRIM_C2B_ADDR, TRIM_C3C_ADDR, TRIM_C3D_ADDR,
                               TRIM_C4_ADDR, TRIM_C5_ADDR, GAIN_C0_ADDR, GAIN_C1_ADDR,
                               GAIN_C2A_ADDR};
  cogt_trim_regs dut (.clk, .resetn, .addr, .wdata, .wr_en, .rd_en, .rdata, .fuse_data,
                      .core2_sel_b, .core3_sel_d, .trim, .fuse_done);
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task tally_and_finish;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish
  task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr
  task rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge clk);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 chk(rdata, e);
  endtask : rd
  task rd_all;
    for (int i = 0; i < 9; i++) rd(at[i], {4'h0, ev[i]});
  endtask : rd_all
  // both input selections of cores 2 and 3
  task trims;
    for (int s = 0; s < 2; s++) begin
      @(posedge clk);
      core2_sel_b <= s[0];
      core3_sel_d <= s[0];
      repeat (2) @(posedge clk);
      #1 chk(trim.core2_ofs, ev[s]);
      chk(trim.core3_ofs, ev[2+s]);
      chk(trim.core4_ofs, ev[4]);
      chk(trim.core5_ofs, ev[5]);
      chk(trim.core0_gain, ev[6]);
      chk(trim.core1_gain, ev[7]);
      chk(trim.core2_gain, (s == 1) ? 12'h000 : ev[8]);
    end
  endtask : trims
  task boot;
    @(posedge clk);
    resetn <= 1'b0;
    for (int i = 0; i < 9; i++) ev[i] = (i < 6) ? fuse_data.ofs[i] : 12'(fuse_data.gain[i-6]);
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    for (int i = 0; i < 20 && fuse_done !== 1'b1; i++) @(posedge clk);
    if (fuse_done !== 1'b1) begin
      n_fail++;
      tally_and_finish();
    end
  endtask : boot
  initial begin
    resetn = 1'b0;
    {wr_en, rd_en, core2_sel_b, core3_sel_d} = 4'h0;
    addr = 12'h000;
    wdata = 16'h0000;
    n_fail = 0;
    compares = 0;
    for (int i = 0; i < 6; i++) fuse_data.ofs[i] = 12'h8f0 + 12'(i);
    for (int j = 0; j < 3; j++) fuse_data.gain[j] = 5'h11 + 5'(j);
    boot();
    rd(STATUS_ADDR, 16'h0001);
    rd_all();
    trims();
    rd(12'h100, 16'h0000);
    for (int i = 0; i < 9; i++) begin
      ev[i] = (i < 6) ? 12'hf5a - 12'(i) : 12'(5'h1e - 5'(i));
      wr(at[i], {4'h0, ev[i]});
    end
    wr(12'h100, 16'h0fff);
    rd(12'h100, 16'h0000);
    rd_all();
    trims();
    boot();
    rd(STATUS_ADDR, 16'h0001);
    rd_all();
    tally_and_finish();
  end
  initial begin
    #50000;
    n_fail++;
    tally_and_finish();
  end
endmodule : cogt_trim_regs_tb
`default_nettype wire
